// >>> descriptor_done_irq_masking.sv
// descriptor-done interrupt masking, event status and avalon register slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps

module descriptor_done_irq_masking
  import irq_mask_pkg::*;
#(
  parameter int DESC_COUNT = 32
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire avmm_req_t bus_req,
  output avmm_rsp_t bus_rsp,
  input wire logic dma_done_evt,
  input wire logic frame_start_evt,
  input wire logic [DESC_COUNT-1:0] iso_done_map,
  input wire logic [DESC_COUNT-1:0] int_done_map,
  input wire logic [DESC_COUNT-1:0] async_done_map,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [DATA_W-1:0] host_irq_enable;
  logic [DESC_COUNT-1:0] iso_done_or_mask;
  logic [DESC_COUNT-1:0] int_done_or_mask;
  logic [DESC_COUNT-1:0] async_done_or_mask;
  logic [DESC_COUNT-1:0] iso_done_and_mask;
  logic [DESC_COUNT-1:0] int_done_and_mask;
  logic [DESC_COUNT-1:0] async_done_and_mask;
  logic [DATA_W-1:0] irq_status;

  bus_state_t bus_state;
  logic req_seen;
  logic wr_take;
  logic rd_take;
  logic [DATA_W-1:0] next_readdata;

  logic dma_irq_enable;
  logic frame_start_irq_enable;
  logic async_list_irq_enable;
  logic iso_list_irq_enable;
  logic int_list_irq_enable;

  assign dma_irq_enable = host_irq_enable[BIT_DMA_DONE];
  assign frame_start_irq_enable = host_irq_enable[BIT_FRAME_START];
  assign async_list_irq_enable = host_irq_enable[BIT_ASYNC_LIST];
  assign iso_list_irq_enable = host_irq_enable[BIT_ISO_LIST];
  assign int_list_irq_enable = host_irq_enable[BIT_INT_LIST];

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  assign req_seen = bus_req.read | bus_req.write;
  assign wr_take = bus_req.write & (bus_state == BUS_ACK);
  assign rd_take = bus_req.read & (bus_state == BUS_ACK);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      bus_state <= BUS_IDLE;
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (req_seen)
            bus_state <= BUS_ACK;
        end
        BUS_ACK:
          bus_state <= BUS_IDLE;
        default:
          bus_state <= BUS_IDLE;
      endcase
    end
  end

  // readback decode; unmapped and write-only offsets read zero
  always_comb
  begin
    next_readdata = '0;
    case (bus_req.address)
      OFS_IRQ_ENABLE:
        next_readdata = host_irq_enable;
      OFS_ISO_OR:
        next_readdata = DATA_W'(iso_done_or_mask);
      OFS_INT_OR:
        next_readdata = DATA_W'(int_done_or_mask);
      OFS_ASYNC_OR:
        next_readdata = DATA_W'(async_done_or_mask);
      OFS_ISO_AND:
        next_readdata = DATA_W'(iso_done_and_mask);
      OFS_INT_AND:
        next_readdata = DATA_W'(int_done_and_mask);
      OFS_ASYNC_AND:
        next_readdata = DATA_W'(async_done_and_mask);
      OFS_IRQ_STATUS:
        next_readdata = irq_status;
      default:
        next_readdata = '0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      bus_rsp.readdata <= '0;
      bus_rsp.waitrequest <= 1'b1;
    end
    else
    begin
      // waitrequest drops for exactly the acknowledge cycle
      bus_rsp.waitrequest <= !(req_seen && bus_state == BUS_IDLE);
      if (bus_req.read && bus_state == BUS_IDLE)
        bus_rsp.readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable and mask registers

  // reserved enable bits are stored as written; the host model keeps only bits 0, 2 and 4 at reset
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      host_irq_enable <= ENABLE_RESET;
    else if (wr_take && bus_req.address == OFS_IRQ_ENABLE)
      host_irq_enable <= bus_req.writedata;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      iso_done_or_mask <= DESC_COUNT'(MASK_RESET);
      int_done_or_mask <= DESC_COUNT'(MASK_RESET);
      async_done_or_mask <= DESC_COUNT'(MASK_RESET);
      iso_done_and_mask <= DESC_COUNT'(MASK_RESET);
      int_done_and_mask <= DESC_COUNT'(MASK_RESET);
      async_done_and_mask <= DESC_COUNT'(MASK_RESET);
    end
    else if (wr_take)
    begin
      // bit n of each mask is descriptor n of its list
      case (bus_req.address)
        OFS_ISO_OR:
          iso_done_or_mask <= bus_req.writedata[DESC_COUNT-1:0];
        OFS_INT_OR:
          int_done_or_mask <= bus_req.writedata[DESC_COUNT-1:0];
        OFS_ASYNC_OR:
          async_done_or_mask <= bus_req.writedata[DESC_COUNT-1:0];
        OFS_ISO_AND:
          iso_done_and_mask <= bus_req.writedata[DESC_COUNT-1:0];
        OFS_INT_AND:
          int_done_and_mask <= bus_req.writedata[DESC_COUNT-1:0];
        OFS_ASYNC_AND:
          async_done_and_mask <= bus_req.writedata[DESC_COUNT-1:0];
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // list completion conditions

  // done maps come from the descriptor engine on this clock; a set bit
  // means that descriptor has completed, and this block never alters it
  logic iso_or_hit;
  logic int_or_hit;
  logic async_or_hit;
  logic iso_and_hit;
  logic int_and_hit;
  logic async_and_hit;
  logic iso_cond;
  logic int_cond;
  logic async_cond;
  logic iso_cond_q;
  logic int_cond_q;
  logic async_cond_q;

  assign iso_or_hit = |(iso_done_map & iso_done_or_mask);
  assign int_or_hit = |(int_done_map & int_done_or_mask);
  assign async_or_hit = |(async_done_map & async_done_or_mask);

  // an empty and mask defines no group, so it never fires on its own
  assign iso_and_hit = (|iso_done_and_mask)
    && ((iso_done_map & iso_done_and_mask) == iso_done_and_mask);
  assign int_and_hit = (|int_done_and_mask)
    && ((int_done_map & int_done_and_mask) == int_done_and_mask);
  assign async_and_hit = (|async_done_and_mask)
    && ((async_done_map & async_done_and_mask) == async_done_and_mask);

  assign iso_cond = iso_or_hit | iso_and_hit;
  assign int_cond = int_or_hit | int_and_hit;
  assign async_cond = async_or_hit | async_and_hit;

  // masks are read from registers, so a write counts from the next cycle
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      iso_cond_q <= 1'b0;
      int_cond_q <= 1'b0;
      async_cond_q <= 1'b0;
    end
    else
    begin
      iso_cond_q <= iso_cond;
      int_cond_q <= int_cond;
      async_cond_q <= async_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write-one clear, level irq

  logic [DATA_W-1:0] event_set;
  logic [DATA_W-1:0] event_clr;

  // a condition that stays met fires once; it must fall to fire again
  always_comb
  begin
    event_set = '0;
    event_set[BIT_DMA_DONE] = dma_done_evt;
    event_set[BIT_FRAME_START] = frame_start_evt;
    event_set[BIT_ISO_LIST] = iso_cond & ~iso_cond_q;
    event_set[BIT_INT_LIST] = int_cond & ~int_cond_q;
    event_set[BIT_ASYNC_LIST] = async_cond & ~async_cond_q;
  end

  assign event_clr = (wr_take && bus_req.address == OFS_IRQ_CLEAR)
    ? (bus_req.writedata & EVENT_BITS) : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      irq_status <= '0;
    else
      irq_status <= (irq_status & ~event_clr) | event_set;
  end

  logic irq_cause;

  // shared by the irq flop and its cause check
  assign irq_cause = |(irq_status & host_irq_enable & EVENT_BITS);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= irq_cause;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic past_valid;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      past_valid <= 1'b0;
    else
      past_valid <= 1'b1;
  end

  dma_irq_raise_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    dma_done_evt && dma_irq_enable && !wr_take |=> ##1 irq
  ) else $error("dma completion with enable did not raise irq");

  frame_irq_raise_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    frame_start_evt && frame_start_irq_enable && !wr_take |=> ##1 irq
  ) else $error("frame start with enable did not raise irq");

  irq_has_cause_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    past_valid && irq |->
      $past(irq_cause)
  ) else $error("irq high without an enabled status bit");

  dma_irq_gated_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !dma_irq_enable && !frame_start_irq_enable && !iso_list_irq_enable
      && !int_list_irq_enable && !async_list_irq_enable |=> !irq
  ) else $error("irq raised with every source disabled");

  mask_reset_zero_a: assert property (
    @(posedge mclk)
    !rstn |=> iso_done_or_mask == '0 && int_done_or_mask == '0
      && async_done_or_mask == '0 && iso_done_and_mask == '0
      && int_done_and_mask == '0 && async_done_and_mask == '0
  ) else $error("mask register not zero after reset");

  iso_or_write_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_take && bus_req.address == OFS_ISO_OR |=>
      iso_done_or_mask == $past(bus_req.writedata[DESC_COUNT-1:0])
  ) else $error("iso or mask did not take the written word");

  async_and_write_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    wr_take && bus_req.address == OFS_ASYNC_AND |=>
      async_done_and_mask == $past(bus_req.writedata[DESC_COUNT-1:0])
  ) else $error("async and mask did not take the written word");

  iso_list_set_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    $rose(iso_cond) && !wr_take |=> irq_status[BIT_ISO_LIST]
  ) else $error("iso list condition did not set status");

  int_list_cause_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    past_valid && $rose(irq_status[BIT_INT_LIST]) |->
      $past(int_or_hit) || $past(int_and_hit)
  ) else $error("interrupt list status set without a mask match");

  async_and_all_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    async_and_hit |->
      (async_done_map | ~async_done_and_mask) == '1
  ) else $error("async and condition met with a selected descriptor open");

  iso_empty_mask_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    iso_done_or_mask == '0 && iso_done_and_mask == '0
      |=> !$rose(irq_status[BIT_ISO_LIST])
  ) else $error("iso status set with both masks empty");

  bus_answer_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    req_seen && bus_rsp.waitrequest && bus_state == BUS_IDLE
      |=> !bus_rsp.waitrequest ##1 bus_rsp.waitrequest
  ) else $error("slave did not answer in one wait cycle");

  iso_and_read_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    rd_take && bus_req.address == OFS_ISO_AND |->
      bus_rsp.readdata == DATA_W'(iso_done_and_mask)
  ) else $error("iso and mask read back a different word");

  dma_status_sticky_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    irq_status[BIT_DMA_DONE] && !event_clr[BIT_DMA_DONE] |=> irq_status[BIT_DMA_DONE]
  ) else $error("dma status bit dropped without a clear");

  dma_status_clear_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    event_clr[BIT_DMA_DONE] && !dma_done_evt |=> !irq_status[BIT_DMA_DONE]
  ) else $error("dma status bit survived its clear");

  frame_irq_gated_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !frame_start_irq_enable && irq_status[BIT_FRAME_START]
      && (irq_status & ~(DATA_W'(1) << BIT_FRAME_START)) == '0 |=> !irq
  ) else $error("disabled frame start raised irq");

  iso_list_irq_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    iso_list_irq_enable && irq_status[BIT_ISO_LIST] && !wr_take |=> irq
  ) else $error("enabled iso list status did not raise irq");

  mask_hold_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !wr_take |=> $stable(iso_done_or_mask) && $stable(async_done_and_mask)
  ) else $error("mask register changed without a write");

endmodule

// >>> irq_mask_pkg.sv
// constants and carrier types for the descriptor-done interrupt masking block
//
// Behaviour
// - dma completion raises irq when enable bit 3
// - frame start raises irq when enable bit 1
// - each mask holds 32 bits, one per descriptor
// - iso or mask at 0x318, resets zero
// - interrupt-list or mask at 0x31c, resets zero
// - async or mask at 0x320, resets zero
// - iso and mask at 0x324, resets zero
// - interrupt-list and mask at 0x328, resets zero
// - async and mask at 0x32c, resets zero
// - or mask bit selects descriptor into or condition
// - and mask bit selects descriptor into and condition
// - zero iso or mask defines no or grouping
// - enable bits 9,8,7 gate iso, async, interrupt lists
// - done map bit set marks descriptor completed
package irq_mask_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h314;
  localparam logic [ADDR_W-1:0] OFS_ISO_OR = 12'h318;
  localparam logic [ADDR_W-1:0] OFS_INT_OR = 12'h31c;
  localparam logic [ADDR_W-1:0] OFS_ASYNC_OR = 12'h320;
  localparam logic [ADDR_W-1:0] OFS_ISO_AND = 12'h324;
  localparam logic [ADDR_W-1:0] OFS_INT_AND = 12'h328;
  localparam logic [ADDR_W-1:0] OFS_ASYNC_AND = 12'h32c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h330;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 12'h334;

  // bit positions shared by enable, status and clear
  localparam int BIT_FRAME_START = 1;
  localparam int BIT_DMA_DONE = 3;
  localparam int BIT_INT_LIST = 7;
  localparam int BIT_ASYNC_LIST = 8;
  localparam int BIT_ISO_LIST = 9;

  localparam logic [DATA_W-1:0] EVENT_BITS = 32'h0000038a;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage

// >>> host_cpu_model.sv
// host processor model driving the avalon register bus
`timescale 1ns/1ps

module host_cpu_model
  import irq_mask_pkg::*;
(
  input wire logic mclk,
  input wire avmm_rsp_t bus_rsp,
  output avmm_req_t bus_req
);
  initial bus_req = '0;

  // holds the request until waitrequest is sampled low; only the bench watchdog ends a dead wait
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    logic [DATA_W-1:0] v;
    v = (wr && a == OFS_IRQ_ENABLE) ? ((d & 32'hffffffea) | (ENABLE_RESET & 32'h15)) : d;
    bus_req <= '{read: !wr, write: wr, address: a, writedata: v};
    @(posedge mclk);
    while (bus_rsp.waitrequest !== 1'b0)
    begin
      @(posedge mclk);
    end
    q = bus_rsp.readdata;
    bus_req <= '0;
    // idle edge so the next request never lands in the release time step
    @(posedge mclk);
  endtask
endmodule

// >>> test_descriptor_done_irq_masking.sv
// self-checking bench for the descriptor-done interrupt masking block
`timescale 1ns/1ps

module test_descriptor_done_irq_masking
  import irq_mask_pkg::*;
  ;
  logic mclk, rstn, dma_done_evt, frame_start_evt, irq;
  logic [31:0] done [3];
  logic [31:0] d;
  logic [ADDR_W-1:0] a;
  avmm_req_t bus_req;
  avmm_rsp_t bus_rsp;
  int n_fail, checks_done, seed;
  localparam logic [ADDR_W-1:0] OR_OFS [3] = '{OFS_ISO_OR, OFS_INT_OR, OFS_ASYNC_OR};
  localparam logic [ADDR_W-1:0] AND_OFS [3] = '{OFS_ISO_AND, OFS_INT_AND, OFS_ASYNC_AND};
  localparam int LIST_BIT [3] = '{BIT_ISO_LIST, BIT_INT_LIST, BIT_ASYNC_LIST};

  descriptor_done_irq_masking u_dut (.mclk(mclk), .rstn(rstn), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .dma_done_evt(dma_done_evt), .frame_start_evt(frame_start_evt),
    .iso_done_map(done[0]), .int_done_map(done[1]), .async_done_map(done[2]), .irq(irq));
  host_cpu_model u_host (.mclk(mclk), .bus_rsp(bus_rsp), .bus_req(bus_req));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] wa, input logic [31:0] wd);
    logic [31:0] q;
    u_host.access(1'b1, wa, wd, q);
  endtask

  task automatic rd(input string nm, input logic [ADDR_W-1:0] ra, input logic [31:0] e);
    logic [31:0] q;
    u_host.access(1'b0, ra, '0, q);
    chk(nm, q, e);
  endtask

  // one event pulse; status is sticky even when the enable bit is off
  task automatic pulse(input bit dma, input logic [31:0] en, input logic exp);
    wr(OFS_IRQ_ENABLE, en);
    dma_done_evt <= dma;
    frame_start_evt <= !dma;
    @(posedge mclk);
    dma_done_evt <= 1'b0;
    frame_start_evt <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
    rd("status", OFS_IRQ_STATUS, 32'h1 << (dma ? BIT_DMA_DONE : BIT_FRAME_START));
    wr(OFS_IRQ_CLEAR, 32'hffffffff);
    @(posedge mclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  task automatic list_case(input int l);
    int k;
    logic [31:0] m, st;
    k = $unsigned($random(seed)) % 31;
    m = (32'h1 << k) | (32'h2 << k);
    st = 32'h1 << LIST_BIT[l];
    wr(AND_OFS[l], m);
    wr(OFS_IRQ_ENABLE, EVENT_BITS);
    done[l] <= ($random(seed) & ~m) | (32'h1 << k);
    repeat (3) @(posedge mclk);
    rd("and partial", OFS_IRQ_STATUS, 32'h0);
    done[l] <= $random(seed) | m;
    repeat (3) @(posedge mclk);
    rd("and full", OFS_IRQ_STATUS, st);
    chk("list irq", {31'h0, irq}, 32'h1);
    done[l] <= '0;
    wr(AND_OFS[l], '0);
    wr(OFS_IRQ_CLEAR, 32'hffffffff);
    wr(OR_OFS[l], 32'h1 << k);
    wr(OFS_IRQ_ENABLE, EVENT_BITS & ~st);
    done[l] <= ~(32'h1 << k);
    repeat (3) @(posedge mclk);
    rd("or other", OFS_IRQ_STATUS, 32'h0);
    done[l] <= '1;
    repeat (3) @(posedge mclk);
    rd("or hit", OFS_IRQ_STATUS, st);
    chk("gated irq", {31'h0, irq}, 32'h0);
    done[l] <= '0;
    wr(OR_OFS[l], '0);
    wr(OFS_IRQ_CLEAR, 32'hffffffff);
    done[l] <= '1;
    repeat (3) @(posedge mclk);
    rd("no grouping", OFS_IRQ_STATUS, 32'h0);
    done[l] <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 94;
    n_fail = 0;
    checks_done = 0;
    rstn = 1'b0;
    dma_done_evt = 1'b0;
    frame_start_evt = 1'b0;
    done = '{default: '0};
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd("enable", OFS_IRQ_ENABLE, ENABLE_RESET);
    for (int i = 0; i < 3; i++)
    begin
      rd("or reset", OR_OFS[i], MASK_RESET);
      rd("and reset", AND_OFS[i], MASK_RESET);
    end
    for (int i = 0; i < 6; i++)
    begin
      d = $random(seed);
      a = (i < 3) ? OR_OFS[i] : AND_OFS[i - 3];
      wr(a, d);
      rd("mask rw", a, d);
      wr(a, '0);
    end
    rd("unmapped", 12'h400, 32'h0);
    pulse(1'b1, 32'h8, 1'b1);
    pulse(1'b1, 32'h0, 1'b0);
    pulse(1'b0, 32'h2, 1'b1);
    pulse(1'b0, 32'h0, 1'b0);
    for (int l = 0; l < 3; l++)
      list_case(l);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
endmodule
